//--- logic/pexp_device.sv
`timescale 1ns/1ps
// Purpose: port expander slave, clocked by the serial clock line
// Assumes: master keeps to the protocol; reset is active high pin
// Notes:   start detect toggles a flop clocked by sda fall while scl high
module pexp_device
   import pexp_pkg::*;
#(
   parameter logic [ADDR_W-1:0] slave_address_param = SLAVE_ADDR_DEFAULT,
   parameter int                IN_PINS             = GPIO_W
)
(
   // reset pin, active high
   input  wire logic              rst_in,
   // link
   pexp_if.device                 link,
   // pins
   input  wire logic [IN_PINS-1:0] gpio_in,
   output logic      [GPIO_W-1:0]  gpio_out
);
   typedef struct packed
   {
      pexp_dev_st_t     st;
      logic [3:0]       cnt;
      logic [7:0]       shift;
      logic             rd;
      logic             start_seen;
   } pexp_dev_s_t;

   pexp_dev_s_t cur_ff;
   pexp_dev_s_t nxt_cur;
   // ****************************************
   // start detection
   // ****************************************
   // toggles on each start; scl domain sees a change as a pulse
   logic start_tgl_ff;
   logic start_pulse;
   logic dev_rst_n;
   assign dev_rst_n = !rst_in;
   always_ff @(negedge link.sda or posedge rst_in)
   begin
      if (rst_in)
         start_tgl_ff <= 1'b0;
      else if (link.scl)
         start_tgl_ff <= ~start_tgl_ff;
   end
   assign start_pulse = start_tgl_ff != cur_ff.start_seen;
   // ****************************************
   // input pin padding
   // ****************************************
   // pins are sampled on scl rises: a level must stand two rises before the ack
   logic [IN_PINS-1:0] gpio_s;
   pexp_sync #(.W(IN_PINS)) u_gpio_sync
   (
      .core_clk_in (link.scl),
      .rst_n_in    (dev_rst_n),
      .async_in    (gpio_in),
      .sync_out    (gpio_s)
   );
   logic [7:0] in_byte;
   always_comb
   begin
      in_byte = 8'hFF;
      in_byte[IN_PINS-1:0] = gpio_s;
   end
   // ****************************************
   // byte machine, rising scl samples sda
   // ****************************************
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.start_seen = start_tgl_ff;
      case (cur_ff.st)
         PEXP_IDLE:
         begin
            nxt_cur.cnt = 4'h0;
         end
         PEXP_ADDR:
         begin
            nxt_cur.shift = {cur_ff.shift[6:0], link.sda};
            nxt_cur.cnt   = cur_ff.cnt + 4'h1;
            if (cur_ff.cnt == 4'(BITS_PER_BYTE - 1))
            begin
               nxt_cur.rd = link.sda;
               if (cur_ff.shift[6:0] == slave_address_param)
               begin
                  nxt_cur.st = PEXP_AACK;
               end
               else
               begin
                  nxt_cur.st = PEXP_IDLE;
               end
            end
         end
         PEXP_AACK:
         begin
            nxt_cur.cnt = 4'h0;
            if (cur_ff.rd)
            begin
               nxt_cur.st    = PEXP_RDATA;
               nxt_cur.shift = in_byte;
            end
            else
            begin
               nxt_cur.st = PEXP_WDATA;
            end
         end
         PEXP_WDATA:
         begin
            nxt_cur.shift = {cur_ff.shift[6:0], link.sda};
            nxt_cur.cnt   = cur_ff.cnt + 4'h1;
            if (cur_ff.cnt == 4'(BITS_PER_BYTE - 1))
               nxt_cur.st = PEXP_WACK;
         end
         PEXP_WACK:
         begin
            nxt_cur.st = PEXP_IDLE;
         end
         PEXP_RDATA:
         begin
            nxt_cur.cnt = cur_ff.cnt + 4'h1;
            if (cur_ff.cnt != 4'(BITS_PER_BYTE - 1))
               nxt_cur.shift = {cur_ff.shift[6:0], 1'b1};
            else
               nxt_cur.st = PEXP_RACK;
         end
         PEXP_RACK:
         begin
            nxt_cur.st = PEXP_IDLE;
         end
         default:
         begin
            nxt_cur.st = PEXP_IDLE;
         end
      endcase
      if (start_pulse)
      begin
         nxt_cur.st  = PEXP_ADDR;
         nxt_cur.shift = {7'h00, link.sda};
         nxt_cur.cnt = 4'h1;
      end
   end
   always_ff @(posedge link.scl or posedge rst_in)
   begin
      if (rst_in)
      begin
         cur_ff <= '{st: PEXP_IDLE, cnt: 4'h0, shift: 8'h00, rd: 1'b0,
                     start_seen: 1'b0};
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end
   // ****************************************
   // falling scl: drive ack and read bits
   // ****************************************
   // sda only changes while scl is low, so no false start is seen
   logic              drv_lo_ff;
   logic [GPIO_W-1:0] outs_ff;
   always_ff @(negedge link.scl or posedge rst_in)
   begin
      if (rst_in)
      begin
         drv_lo_ff <= 1'b0;
         outs_ff   <= OUT_RST_VAL;
      end
      else
      begin
         case (cur_ff.st)
            PEXP_AACK:  drv_lo_ff <= 1'b1;
            PEXP_WACK:
            begin
               drv_lo_ff <= 1'b1;
               outs_ff   <= cur_ff.shift;
            end
            PEXP_RDATA: drv_lo_ff <= !cur_ff.shift[7];
            default:    drv_lo_ff <= 1'b0;
         endcase
      end
   end
   assign link.sda_out_d  = 1'b0;
   assign link.sda_oe_n_d = !drv_lo_ff;
   assign gpio_out        = outs_ff;
endmodule // pexp_device

//--- inc/pexp_pkg.sv
// Purpose: shared constants and types for the serial port expander
// Assumes: one start, address byte, one data byte per transaction
// Notes:   timing counts are in system clock cycles of the master end
package pexp_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int GPIO_W         = 8;
   localparam int ADDR_W         = 7;
   localparam int BITS_PER_BYTE  = 8;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] OUT_RST_VAL = 8'h00;
   localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h56;
   // ****************************************
   // timing of the master end
   // ****************************************
   localparam int CORE_CLK_MHZ   = 100;
   localparam int SCL_HALF_NS    = 50;
   localparam int SCL_HALF_CYC   = (SCL_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;
   // ****************************************
   // device states
   // ****************************************
   typedef enum logic [2:0]
   {
      PEXP_IDLE  = 3'b000,
      PEXP_ADDR  = 3'b001,
      PEXP_AACK  = 3'b010,
      PEXP_WDATA = 3'b011,
      PEXP_WACK  = 3'b100,
      PEXP_RDATA = 3'b101,
      PEXP_RACK  = 3'b110
   } pexp_dev_st_t;
endpackage

//--- inc/pexp_if.sv
`timescale 1ns/1ps
// Purpose: two-wire link between master end and expander end
// Assumes: open-drain wires, pulled high when nobody drives low
// Notes:   enables are low while a party drives the wire low
interface pexp_if;
   logic scl_out_m;
   logic scl_oe_n_m;
   logic sda_out_m;
   logic sda_oe_n_m;
   logic sda_out_d;
   logic sda_oe_n_d;
   logic scl;
   logic sda;
   // wired-and with pull-up
   assign scl = !( !scl_oe_n_m && !scl_out_m );
   assign sda = !((!sda_oe_n_m && !sda_out_m) || (!sda_oe_n_d && !sda_out_d));
   modport master (output scl_out_m, output scl_oe_n_m, output sda_out_m,
                   output sda_oe_n_m, input scl, input sda);
   modport device (output sda_out_d, output sda_oe_n_d, input scl, input sda);
endinterface

//--- logic/pexp_sync.sv
`timescale 1ns/1ps
// Purpose: two flip-flop level synchroniser
// Assumes: asynchronous input
// Notes:   first stage is read only by the second
module pexp_sync
   import pexp_pkg::*;
#(
   parameter int W = 1
)
(
   // clock and reset
   input  wire logic         core_clk_in,
   input  wire logic         rst_n_in,
   // data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_ff <= '1;
         sync_ff <= '1;
      end
      else
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end
   assign sync_out = sync_ff;
endmodule // pexp_sync

//--- logic/pexp_master.sv
`timescale 1ns/1ps
// Purpose: bus master end issuing one-byte write or read transactions
// Assumes: core clock 100 MHz; scl derived by divider
// Notes:   no stop condition; lines return high after the ack bit
module pexp_master
   import pexp_pkg::*;
(
   // clock and reset
   input  wire logic         core_clk_in,
   input  wire logic         rst_n_in,
   // request
   input  wire logic         req_in,
   input  wire logic         rd_in,
   input  wire logic [6:0]   addr_in,
   input  wire logic [7:0]   wdata_in,
   output logic              busy_out,
   output logic              done_out,
   output logic              ack_ok_out,
   output logic [7:0]        rdata_out,
   // link
   pexp_if.master            link
);
   logic sda_s;
   pexp_sync #(.W(1)) u_sda_sync
   (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .async_in    (link.sda),
      .sync_out    (sda_s)
   );
   typedef struct packed
   {
      logic        busy;
      logic [1:0]  phase;
      logic [4:0]  bitn;
      logic [7:0]  div;
      logic        scl;
      logic        sda;
      logic [17:0] tx;
      logic        rd;
      logic        ack_ok;
      logic [7:0]  rx;
      logic        done;
   } pexp_m_s_t;
   pexp_m_s_t m_ff;
   pexp_m_s_t nxt_m;
   // bit 9 and 18 are acknowledge slots; 0 means start slot
   always_comb
   begin
      nxt_m = m_ff;
      nxt_m.done = 1'b0;
      if (!m_ff.busy)
      begin
         if (req_in)
         begin
            nxt_m.busy = 1'b1;
            nxt_m.rd   = rd_in;
            nxt_m.tx   = {addr_in, rd_in, 1'b1, (rd_in ? 8'hFF : wdata_in), 1'b1};
            nxt_m.bitn = 5'h0;
            nxt_m.phase = 2'h0;
            nxt_m.div  = 8'h0;
            nxt_m.ack_ok = 1'b1;
         end
      end
      else if (m_ff.div != 8'(SCL_HALF_CYC - 1))
         nxt_m.div = m_ff.div + 8'h1;
      else
      begin
         nxt_m.div = 8'h0;
         nxt_m.phase = m_ff.phase + 2'h1;
         if (m_ff.bitn == 5'h0)
         begin
            // start: sda falls with scl high, then scl falls
            case (m_ff.phase)
               2'h0: nxt_m.sda = 1'b0;
               default:
               begin
                  nxt_m.scl = 1'b0;
                  nxt_m.bitn = 5'h1;
                  nxt_m.phase = 2'h0;
               end
            endcase
         end
         else if (m_ff.bitn == 5'd19)
         begin
            // closing slot: release sda with scl low, then raise scl
            case (m_ff.phase)
               2'h0: nxt_m.sda = 1'b1;
               default:
               begin
                  nxt_m.scl   = 1'b1;
                  nxt_m.phase = 2'h0;
                  nxt_m.busy  = 1'b0;
                  nxt_m.done  = 1'b1;
               end
            endcase
         end
         else
         begin
            case (m_ff.phase)
               2'h0:
               begin
                  nxt_m.sda = m_ff.tx[17];
                  if (m_ff.rd && m_ff.bitn == 5'd18)
                     nxt_m.sda = 1'b0;
               end
               2'h1: nxt_m.scl = 1'b1;
               default:
               begin
                  nxt_m.scl = 1'b0;
                  nxt_m.phase = 2'h0;
                  nxt_m.tx = {m_ff.tx[16:0], 1'b1};
                  nxt_m.bitn = m_ff.bitn + 5'h1;
                  if (m_ff.bitn == 5'd9 && sda_s)
                     nxt_m.ack_ok = 1'b0;
                  if (!m_ff.rd && m_ff.bitn == 5'd18 && sda_s)
                     nxt_m.ack_ok = 1'b0;
                  if (m_ff.rd && m_ff.bitn >= 5'd10 && m_ff.bitn <= 5'd17)
                     nxt_m.rx = {m_ff.rx[6:0], sda_s};
                  // scl must fall after the last ack, else the device
                  // never gets an edge to let go of sda
                  if (m_ff.bitn == 5'd18 || (m_ff.bitn == 5'd9 && sda_s))
                     nxt_m.bitn = 5'd19;
               end
            endcase
         end
      end
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         m_ff <= '{busy: 1'b0, phase: 2'h0, bitn: 5'h0, div: 8'h0, scl: 1'b1,
                   sda: 1'b1, tx: 18'h0, rd: 1'b0, ack_ok: 1'b0, rx: 8'h00,
                   done: 1'b0};
      else
         m_ff <= nxt_m;
   end
   assign link.scl_out_m  = 1'b0;
   assign link.scl_oe_n_m = m_ff.scl;
   assign link.sda_out_m  = 1'b0;
   assign link.sda_oe_n_m = m_ff.sda;
   assign busy_out   = m_ff.busy;
   assign done_out   = m_ff.done;
   assign ack_ok_out = m_ff.ack_ok;
   assign rdata_out  = m_ff.rx;
endmodule // pexp_master

//--- bench/pexp_asserts.sv
// Purpose: protocol checks on the expander link
// Assumes: one master end and one device end on the link
// Notes:   bit position is tracked by sampling scl on the core clock
`timescale 1ns/1ps
module pexp_asserts
   import pexp_pkg::*;
#(
   parameter logic [ADDR_W-1:0] slave_address_param = SLAVE_ADDR_DEFAULT
)
(
   // clocks and resets
   input wire logic              core_clk_in,
   input wire logic              rst_n_in,
   input wire logic              rst_in,
   // link and pins
   input wire logic              scl,
   input wire logic              sda,
   input wire logic              scl_oe_n_m,
   input wire logic              sda_oe_n_m,
   input wire logic              sda_oe_n_d,
   input wire logic [GPIO_W-1:0] gpio_out
);
   // ****************************************
   // bit tracking
   // ****************************************
   logic [4:0] cnt_ff;
   logic [6:0] adr_ff;
   logic       rw_ff;
   logic [7:0] dat_ff;
   logic       scl_q_ff;
   logic       sda_q_ff;
   logic       start;
   logic       rise;
   logic       hit;
   assign start = scl && scl_q_ff && sda_q_ff && !sda;
   assign rise  = scl && !scl_q_ff;
   assign hit   = (adr_ff == slave_address_param);
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt_ff   <= 5'h00;
         adr_ff   <= 7'h00;
         rw_ff    <= 1'b0;
         dat_ff   <= 8'h00;
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end
      else
      begin
         scl_q_ff <= scl;
         sda_q_ff <= sda;
         if (start)
            cnt_ff <= 5'h00;
         else if (rise && cnt_ff != 5'h1F)
         begin
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff < 5'h07)
               adr_ff <= {adr_ff[5:0], sda};
            if (cnt_ff == 5'h07)
               rw_ff <= sda;
            if (cnt_ff > 5'h08 && cnt_ff < 5'h11)
               dat_ff <= {dat_ff[6:0], sda};
         end
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   default clocking dck @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in || rst_in);
   addr_ack_a: assert property (rise && cnt_ff == 5'h08 |-> sda_oe_n_d == !hit)
      else $error("address acknowledge wrong");
   data_ack_a: assert property (rise && cnt_ff == 5'h11 && hit && !rw_ff |-> !sda_oe_n_d)
      else $error("write data not acknowledged");
   out_map_a: assert property (rise && cnt_ff == 5'h11 && hit && !rw_ff |-> gpio_out == dat_ff)
      else $error("outputs do not match written byte");
   rd_free_a: assert property (rise && cnt_ff > 5'h08 && cnt_ff < 5'h11 && rw_ff && hit |-> sda_oe_n_m)
      else $error("master drives data during read");
   rd_ack_a: assert property (rise && cnt_ff == 5'h11 && rw_ff && hit |-> !sda_oe_n_m && sda_oe_n_d)
      else $error("read byte acknowledge wrong");
   miss_quiet_a: assert property (cnt_ff > 5'h07 && !hit |-> sda_oe_n_d)
      else $error("device drives data for other address");
   dev_reset_a: assert property (disable iff (!rst_n_in) rst_in |-> sda_oe_n_d && gpio_out == OUT_RST_VAL)
      else $error("device reset state wrong");
   scl_owner_a: assert property ($rose(scl) |-> scl[*5])
      else $error("clock high time shorter than a half slot");
   start_hold_a: assert property (start |-> scl[*3] ##[1:6] !scl)
      else $error("start condition shape wrong");
   cover property (rise && cnt_ff == 5'h11 && hit && !rw_ff);
   cover property (rise && cnt_ff == 5'h11 && hit && rw_ff);
   cover property (rise && cnt_ff == 5'h08 && !hit);
endmodule // pexp_asserts

//--- bench/i2c_port_expander_tb.sv
// Purpose: self-checking bench for the master end and expander end
// Assumes: both ends joined by one link interface
// Notes:   wire traffic is also watched here, beside the checker
`timescale 1ns/1ps
module i2c_port_expander_tb
   import pexp_pkg::*;
   ;
   logic       core_clk_in;
   logic       rst_n_in;
   logic       rst_in;
   logic       req_in;
   logic       rd_in;
   logic [6:0] addr_in;
   logic [7:0] wdata_in;
   logic       busy_out;
   logic       done_out;
   logic       ack_ok_out;
   logic [7:0] rdata_out;
   logic [7:0] gpio_in;
   logic [7:0] gpio_out;
   logic [4:0] wire_cnt;
   logic [7:0] wire_byte;
   int         fail_count;
   int         checks_done;
   pexp_if link_if ();
   pexp_master pexp_master_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .req_in(req_in), .rd_in(rd_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .busy_out(busy_out), .done_out(done_out), .ack_ok_out(ack_ok_out),
      .rdata_out(rdata_out), .link(link_if));
   pexp_device #(.slave_address_param(SLAVE_ADDR_DEFAULT), .IN_PINS(8)) pexp_device_inst (
      .rst_in(rst_in), .link(link_if), .gpio_in(gpio_in), .gpio_out(gpio_out));
   pexp_asserts #(.slave_address_param(SLAVE_ADDR_DEFAULT)) pexp_asserts_inst (
      .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .rst_in(rst_in),
      .scl(link_if.scl), .sda(link_if.sda), .scl_oe_n_m(link_if.scl_oe_n_m),
      .sda_oe_n_m(link_if.sda_oe_n_m), .sda_oe_n_d(link_if.sda_oe_n_d), .gpio_out(gpio_out));
   // ****************************************
   // wire watch: clock falls since start, first byte
   // ****************************************
   always @(negedge link_if.sda)
      if (link_if.scl === 1'b1)
         wire_cnt = 5'h00;
   always @(negedge link_if.scl)
      wire_cnt = wire_cnt + 5'h01;
   always @(posedge link_if.scl)
      if (wire_cnt > 5'h00 && wire_cnt < 5'h09)
         wire_byte = {wire_byte[6:0], link_if.sda};
   initial
   begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // falls counted include the one closing the start
   task automatic xfer(input logic rd, input logic [6:0] adr, input logic [7:0] wd,
                       input logic ack, input logic [4:0] falls);
      int n;
      check("idle lines", {6'h00, link_if.scl, link_if.sda}, 8'h03);
      rd_in = rd;
      addr_in = adr;
      wdata_in = wd;
      req_in = 1'b1;
      @(negedge core_clk_in);
      req_in = 1'b0;
      check("busy", {7'h00, busy_out}, 8'h01);
      n = 0;
      while (done_out !== 1'b1 && n < 2000)
      begin
         @(negedge core_clk_in);
         n++;
      end
      check("done", {7'h00, done_out}, 8'h01);
      check("free", {7'h00, busy_out}, 8'h00);
      check("ack", {7'h00, ack_ok_out}, {7'h00, ack});
      check("clock falls", {3'h0, wire_cnt}, {3'h0, falls});
      check("first byte", wire_byte, {adr, rd});
      repeat (20) @(negedge core_clk_in);
   endtask
   task automatic t_write();
      xfer(1'b0, SLAVE_ADDR_DEFAULT, 8'hA5, 1'b1, 5'h13);
      check("out a5", gpio_out, 8'hA5);
      xfer(1'b0, SLAVE_ADDR_DEFAULT, 8'h5A, 1'b1, 5'h13);
      check("out 5a", gpio_out, 8'h5A);
   endtask
   task automatic t_read();
      gpio_in = 8'h3C;
      xfer(1'b1, SLAVE_ADDR_DEFAULT, 8'h00, 1'b1, 5'h13);
      check("read 3c", rdata_out, 8'h3C);
      gpio_in = 8'hC1;
      xfer(1'b1, SLAVE_ADDR_DEFAULT, 8'h00, 1'b1, 5'h13);
      check("read c1", rdata_out, 8'hC1);
      check("out kept", gpio_out, 8'h5A);
   endtask
   task automatic t_miss();
      xfer(1'b0, 7'h2B, 8'hFF, 1'b0, 5'h0A);
      check("out after miss", gpio_out, 8'h5A);
   endtask
   task automatic t_devrst();
      rst_in = 1'b1;
      repeat (2) @(negedge core_clk_in);
      check("out in reset", gpio_out, OUT_RST_VAL);
      rst_in = 1'b0;
      @(negedge core_clk_in);
      xfer(1'b0, SLAVE_ADDR_DEFAULT, 8'h81, 1'b1, 5'h13);
      check("out 81", gpio_out, 8'h81);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // about 6 transfers of 300 cycles each; far more is a hang
   initial
   begin
      #200000;
      fail_count++;
      summarize();
   end
   initial
   begin
      fail_count = 0;
      checks_done = 0;
      wire_cnt = 5'h00;
      wire_byte = 8'h00;
      rst_n_in = 1'b0;
      rst_in = 1'b1;
      req_in = 1'b0;
      rd_in = 1'b0;
      addr_in = 7'h00;
      wdata_in = 8'h00;
      gpio_in = 8'h00;
      repeat (12) @(negedge core_clk_in);
      rst_n_in = 1'b1;
      rst_in = 1'b0;
      check("out after reset", gpio_out, OUT_RST_VAL);
      t_write();
      t_read();
      t_miss();
      t_devrst();
      summarize();
   end
endmodule // i2c_port_expander_tb
